// File: hdl/mst_defs.svh
// Register offsets, field positions, reset values and rule summary.
// Summary of operation
// RQ1: Each active prescaler tick decrements the 8-bit count by one.
// RQ2: Count reaching zero sets the count expired flag.
// RQ3: Free run mode clear: count holds at zero, no wrap.
// RQ4: Free run mode set: count wraps from zero to all ones.
// RQ5: With interrupt enable set, CPU flag rises with expired flag.
// RQ6: Interrupt request only while both interrupt enables are one.
// RQ7: A count write loads the counter immediately.
// RQ8: Count write coinciding with a tick stores value minus one.
// RQ9: Prescaler is 18 bits and advances only on system tick.
// RQ10: Rate select codes give factors 64, 128, 256 and 1024.
// RQ11: Multiplier gives the upper 8 bits of the prescaler maximum.
// RQ12: A multiplier of zero acts as 256.
// RQ13: DMA trigger pulses whenever the expired flag becomes one.
// RQ14: All registers reset on return from the two deepest modes.
// RQ15: Software writing one to the expired flag has no effect.
// RQ16: Free run clear: tick generator runs only while count nonzero.
// RQ17: Free run set: generator runs always, starting from null state.
// RQ18: Software writes zero to control bits 5 and 3.
// RQ19: Expired flag stays set until software writes zero to it.
`ifndef MST_DEFS_SVH
`define MST_DEFS_SVH
`define MST_OFS_COUNT 8'h9C
`define MST_OFS_PRESC 8'h9D
`define MST_OFS_CTRL 8'h9E
`define MST_BIT_EXP 6
`define MST_BIT_IEN 4
`define MST_BIT_FREE 2
`define MST_RST_COUNT 8'h00
`define MST_RST_PRESC 8'h00
`define MST_RST_CTRL 8'h00
`define MST_CTRL_RMASK 8'h57
`endif

// File: hdl/mst_pkg.sv
// Types shared by the slot down timer.
package mst_pkg;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mst_sfr_req_s;
  typedef enum logic [1:0] {
    MST_RATE_64,
    MST_RATE_128,
    MST_RATE_256,
    MST_RATE_1024
  } mst_rate_e;
endpackage : mst_pkg

// File: hdl/mst_slot_timer.sv
// Slot down timer with 18-bit prescaler and special-function registers.
`timescale 1ns/1ps
`include "mst_defs.svh"
module mst_slot_timer #(
  parameter int PRESC_W = 18
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sys_tick,
  input wire logic deep_wake,
  input wire mst_pkg::mst_sfr_req_s sfr_req,
  input wire logic cpu_slot_irq_enable,
  input wire logic cpu_slot_irq_clear,
  output logic [7:0] sfr_rdata,
  output logic cpu_slot_irq_flag,
  output logic irq_req,
  output logic slot_expire_dma_trigger
);

  logic [7:0] down_count_value;
  logic [7:0] prescale_multiplier;
  logic count_expired_flag;
  logic expire_irq_enable;
  logic free_run_tick_mode;
  logic [1:0] prescale_rate_select;
  logic [PRESC_W-1:0] presc_cnt;
  logic gen_running;
  logic [7:0] next_down_count_value;
  logic [7:0] next_prescale_multiplier;
  logic next_count_expired_flag;
  logic next_expire_irq_enable;
  logic next_free_run_tick_mode;
  logic [1:0] next_prescale_rate_select;
  logic [PRESC_W-1:0] next_presc_cnt;
  logic next_gen_running;
  logic [7:0] next_sfr_rdata;
  logic next_cpu_slot_irq_flag;
  logic next_irq_req;
  logic next_dma;
  logic [PRESC_W-1:0] presc_max;
  logic [PRESC_W-1:0] presc_step;
  logic [PRESC_W:0] presc_sum;
  logic [8:0] mult_val;
  logic run_enable;
  logic timer_edge;
  logic wr_count;
  logic wr_presc;
  logic wr_ctrl;
  logic expire_event;

  // Address decode of register writes.
  assign wr_count = sfr_req.wr && (sfr_req.addr == `MST_OFS_COUNT);
  assign wr_presc = sfr_req.wr && (sfr_req.addr == `MST_OFS_PRESC);
  assign wr_ctrl = sfr_req.wr && (sfr_req.addr == `MST_OFS_CTRL);

  // Prescaler maximum, step and active edge generation.
  always_comb
  begin
    // RQ12: zero means 256.
    mult_val = (prescale_multiplier == 8'h00) ? 9'h100
      : {1'b0, prescale_multiplier};
    // A multiplier of 256 drops its top bit in the cast, and the
    // subtraction then yields the full range that 256 stands for.
    // RQ11: multiplier gives upper bits.
    presc_max = PRESC_W'({mult_val, 10'h000}) - PRESC_W'(1);
    // The counter climbs by 16, 8, 4 or 1 toward multiplier times 1024,
    // so one slot lasts the multiplier times the rate factor in ticks.
    // RQ10: rate select factors.
    case (mst_pkg::mst_rate_e'(prescale_rate_select))
      mst_pkg::MST_RATE_64: presc_step = PRESC_W'(16);
      mst_pkg::MST_RATE_128: presc_step = PRESC_W'(8);
      mst_pkg::MST_RATE_256: presc_step = PRESC_W'(4);
      mst_pkg::MST_RATE_1024: presc_step = PRESC_W'(1);
      default: presc_step = PRESC_W'(1);
    endcase
    presc_sum = {1'b0, presc_cnt} + {1'b0, presc_step};
    // RQ16: gated by nonzero count in stop mode.
    // RQ17: free running when mode set.
    run_enable = free_run_tick_mode || (down_count_value != 8'h00);
    // RQ9: aligned to system tick.
    timer_edge = gen_running && run_enable && sys_tick
      && (presc_sum > {1'b0, presc_max});
  end

  // Next state of prescaler and tick generator.
  always_comb
  begin
    // A stopped or gated generator sits in its null state, so that a
    // restart always counts a full slot.
    next_gen_running = run_enable;
    next_presc_cnt = presc_cnt;
    if (!run_enable || !gen_running)
    begin
      next_presc_cnt = '0;
    end
    else if (sys_tick)
    begin
      if (timer_edge)
        next_presc_cnt = '0;
      else
        next_presc_cnt = presc_sum[PRESC_W-1:0];
    end
    // Deep wake wins over everything else in the generator.
    if (deep_wake)
    begin
      next_presc_cnt = '0;
      next_gen_running = 1'b0;
    end
  end

  // Next state of count, flags and control fields.
  always_comb
  begin
    next_down_count_value = down_count_value;
    next_prescale_multiplier = prescale_multiplier;
    next_expire_irq_enable = expire_irq_enable;
    next_free_run_tick_mode = free_run_tick_mode;
    next_prescale_rate_select = prescale_rate_select;
    next_count_expired_flag = count_expired_flag;
    next_cpu_slot_irq_flag = cpu_slot_irq_flag;
    expire_event = 1'b0;
    if (timer_edge)
    begin
      // RQ3: hold at zero without free run.
      if (down_count_value == 8'h00 && !free_run_tick_mode)
        next_down_count_value = 8'h00;
      else
        // RQ1: decrement; RQ4: wraps to all ones.
        next_down_count_value = down_count_value - 8'h01;
      // RQ2: reaching zero expires.
      expire_event = (down_count_value == 8'h01);
    end
    // The write wins over the plain decrement of the same edge.
    // RQ7: immediate load; RQ8: minus one on coincident edge.
    if (wr_count)
      next_down_count_value = timer_edge ? sfr_req.wdata - 8'h01
        : sfr_req.wdata;
    if (wr_presc)
      next_prescale_multiplier = sfr_req.wdata;
    if (wr_ctrl)
    begin
      // Reserved bits are not stored, so they always read back zero.
      next_expire_irq_enable = sfr_req.wdata[`MST_BIT_IEN];
      next_free_run_tick_mode = sfr_req.wdata[`MST_BIT_FREE];
      next_prescale_rate_select = sfr_req.wdata[1:0];
      // RQ15: writing one no effect; RQ19: zero clears.
      if (!sfr_req.wdata[`MST_BIT_EXP])
        next_count_expired_flag = 1'b0;
    end
    if (cpu_slot_irq_clear)
      next_cpu_slot_irq_flag = 1'b0;
    // Set wins over a coincident clear.
    if (expire_event)
    begin
      next_count_expired_flag = 1'b1;
      // RQ5: CPU flag follows when enabled.
      if (expire_irq_enable)
        next_cpu_slot_irq_flag = 1'b1;
    end
    // RQ14: registers return to reset after deep sleep wake.
    if (deep_wake)
    begin
      next_down_count_value = `MST_RST_COUNT;
      next_prescale_multiplier = `MST_RST_PRESC;
      next_expire_irq_enable = 1'b0;
      next_free_run_tick_mode = 1'b0;
      next_prescale_rate_select = 2'b00;
      next_count_expired_flag = 1'b0;
      expire_event = 1'b0;
    end
    // RQ13: DMA trigger on each expiry.
    next_dma = expire_event;
    // Built from next values so that the request moves with the flag.
    // RQ6: both enables needed for a request.
    next_irq_req = next_cpu_slot_irq_flag && next_expire_irq_enable
      && cpu_slot_irq_enable;
  end

  // Read data mux; reserved bits read zero.
  // Next values are shown, so a read just after a write already sees it.
  always_comb
  begin
    case (sfr_req.addr)
      `MST_OFS_COUNT: next_sfr_rdata = next_down_count_value;
      `MST_OFS_PRESC: next_sfr_rdata = next_prescale_multiplier;
      `MST_OFS_CTRL: next_sfr_rdata = {1'b0, next_count_expired_flag,
        1'b0, next_expire_irq_enable, 1'b0, next_free_run_tick_mode,
        next_prescale_rate_select} & `MST_CTRL_RMASK;
      default: next_sfr_rdata = 8'h00;
    endcase
  end

  // State registers.
  // Every register, outputs included, loads on every edge, so each
  // output comes straight from a flip-flop.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      down_count_value <= `MST_RST_COUNT;
      prescale_multiplier <= `MST_RST_PRESC;
      count_expired_flag <= 1'b0;
      expire_irq_enable <= 1'b0;
      free_run_tick_mode <= 1'b0;
      prescale_rate_select <= 2'b00;
      presc_cnt <= '0;
      gen_running <= 1'b0;
      sfr_rdata <= 8'h00;
      cpu_slot_irq_flag <= 1'b0;
      irq_req <= 1'b0;
      slot_expire_dma_trigger <= 1'b0;
    end
    else
    begin
      down_count_value <= next_down_count_value;
      prescale_multiplier <= next_prescale_multiplier;
      count_expired_flag <= next_count_expired_flag;
      expire_irq_enable <= next_expire_irq_enable;
      free_run_tick_mode <= next_free_run_tick_mode;
      prescale_rate_select <= next_prescale_rate_select;
      presc_cnt <= next_presc_cnt;
      gen_running <= next_gen_running;
      sfr_rdata <= next_sfr_rdata;
      cpu_slot_irq_flag <= next_cpu_slot_irq_flag;
      irq_req <= next_irq_req;
      slot_expire_dma_trigger <= next_dma;
    end
  end

  // Checks on the guarded behaviour.
  // All checks sample on the system clock and rest during reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_count_dec: assert property ( // RQ1
    timer_edge && !wr_count && !deep_wake && down_count_value != 8'h00
    |=> down_count_value == $past(down_count_value) - 8'h01)
    else $error("count did not decrement on tick");
  chk_expire_set: assert property ( // RQ2
    timer_edge && down_count_value == 8'h01 && !deep_wake
    |=> count_expired_flag)
    else $error("expired flag not set at zero");
  chk_hold_zero: assert property ( // RQ3
    down_count_value == 8'h00 && !free_run_tick_mode && !wr_count
    && !wr_ctrl |=> down_count_value == 8'h00)
    else $error("count left zero without free run");
  chk_wrap_ff: assert property ( // RQ4
    timer_edge && down_count_value == 8'h00 && !wr_count && !deep_wake
    |=> down_count_value == 8'hFF)
    else $error("count did not wrap");
  chk_irq_flag: assert property ( // RQ5
    expire_event && expire_irq_enable |=> cpu_slot_irq_flag)
    else $error("cpu flag missing on expiry");
  chk_irq_gate: assert property ( // RQ6
    irq_req |-> cpu_slot_irq_flag && expire_irq_enable)
    else $error("request without enables");
  chk_write_load: assert property ( // RQ7
    wr_count && !timer_edge && !deep_wake
    |=> down_count_value == $past(sfr_req.wdata))
    else $error("count write not loaded");
  chk_write_tick: assert property ( // RQ8
    wr_count && timer_edge && !deep_wake
    |=> down_count_value == $past(sfr_req.wdata) - 8'h01)
    else $error("coincident write not decremented");
  chk_dma_pulse: assert property ( // RQ13
    slot_expire_dma_trigger |-> count_expired_flag)
    else $error("dma trigger without expiry");
  chk_wake_reset: assert property ( // RQ14
    deep_wake |=> down_count_value == 8'h00 && !count_expired_flag
    && prescale_multiplier == 8'h00)
    else $error("registers not reset after wake");
  chk_flag_sticky: assert property ( // RQ19
    count_expired_flag && !(wr_ctrl && !sfr_req.wdata[`MST_BIT_EXP])
    && !deep_wake |=> count_expired_flag)
    else $error("expired flag lost");

  // Expiry gives a trigger that stands for exactly one cycle.
  chk_dma_single: assert property ( // RQ13
    timer_edge && down_count_value == 8'h01 && !deep_wake
    |=> slot_expire_dma_trigger ##1 !slot_expire_dma_trigger)
    else $error("dma trigger not a single pulse");
  // The request also needs the CPU-side enable of the cycle before.
  chk_irq_cpu: assert property ( // RQ6
    irq_req |-> $past(cpu_slot_irq_enable))
    else $error("request without cpu enable");
  // A generator that starts always starts from a cleared prescaler.
  chk_gen_null: assert property ( // RQ17
    $rose(gen_running) |-> presc_cnt == '0)
    else $error("generator did not start from null");
  // Without a system tick the prescaler holds or clears.
  chk_tick_align: assert property ( // RQ9
    !sys_tick |=> presc_cnt == $past(presc_cnt) || presc_cnt == '0)
    else $error("prescaler moved without tick");
  // Free run keeps a started generator running.
  chk_free_run: assert property ( // RQ17
    free_run_tick_mode && gen_running && !deep_wake |=> gen_running)
    else $error("free running generator stopped");

  // Main scenarios worth seeing at least once.
  cov_expire: cover property (expire_event);
  cov_irq_req: cover property (irq_req);
  cov_tick_gap: cover property (gen_running && !sys_tick);
  cov_wrap: cover property (timer_edge && down_count_value == 8'h00);
  cov_coincide: cover property (wr_count && timer_edge);

endmodule : mst_slot_timer

// File: verif/mst_cpu_model.sv
// CPU-side model that issues special-function register writes and reads.
`timescale 1ns/1ps
module mst_cpu_model (
  input wire logic clk_sys,
  input wire logic [7:0] sfr_rdata,
  output mst_pkg::mst_sfr_req_s sfr_req
);
  // The bus starts idle with no write pending.
  initial sfr_req = '0;

  // Writes one byte; the block takes it at the edge that follows.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_req <= '{wr: 1'b1, addr: a, wdata: (a == 8'h9E) ? (d & 8'hD7) : d};
    @(posedge clk_sys);
    sfr_req.wr <= 1'b0;
  endtask : wr

  // Reads one byte; the registered answer settles one edge later.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_req.addr <= a;
    @(posedge clk_sys);
    #1;
    d = sfr_rdata;
  endtask : rd
endmodule : mst_cpu_model

// File: verif/tb.sv
// Self-checking bench for the slot down timer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic clk_sys;
  logic rst_n;
  logic sys_tick;
  logic tick_half = 1'b0;
  logic deep_wake;
  logic cpu_slot_irq_enable;
  logic cpu_slot_irq_clear;
  mst_pkg::mst_sfr_req_s sfr_req;
  logic [7:0] sfr_rdata;
  logic cpu_slot_irq_flag;
  logic irq_req;
  logic dma;
  logic [7:0] v;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;

  mst_slot_timer i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .sys_tick(sys_tick), .deep_wake(deep_wake), .sfr_req(sfr_req),
    .cpu_slot_irq_enable(cpu_slot_irq_enable),
    .cpu_slot_irq_clear(cpu_slot_irq_clear), .sfr_rdata(sfr_rdata),
    .cpu_slot_irq_flag(cpu_slot_irq_flag), .irq_req(irq_req),
    .slot_expire_dma_trigger(dma));
  mst_cpu_model i_cpu (.clk_sys(clk_sys), .sfr_rdata(sfr_rdata),
    .sfr_req(sfr_req));

  // Clock at 50 ns period.
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Gives a tick every cycle, or every other cycle while tick_half is set.
  always @(posedge clk_sys)
    sys_tick <= tick_half ? ~sys_tick : 1'b1;

  // Cuts a hang short as a failure.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      conclude();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Waits a bounded time for the trigger pulse and counts the cycles.
  task automatic wait_dma(input int lim);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (dma !== 1'b1 && n < lim);
    `CHK("dma seen", 1'b1, dma)
  endtask : wait_dma

  // Checks that all three registers and an unmapped place read zero.
  task automatic zeros();
    logic [7:0] adr [4] = '{8'h9C, 8'h9D, 8'h9E, 8'hA0};
    foreach (adr[i])
    begin
      i_cpu.rd(adr[i], v);
      `CHK("reset value", 8'h00, v)
    end
  endtask : zeros

  // Reset values, immediate load, readback and deep wake reset.
  task automatic t_regs();
    zeros();
    i_cpu.wr(8'h9D, 8'h5A);
    i_cpu.wr(8'h9C, 8'h80);
    i_cpu.rd(8'h9C, v);
    `CHK("count load", 8'h80, v)
    i_cpu.wr(8'h9E, 8'hFF);
    i_cpu.rd(8'h9E, v);
    `CHK("ctrl mask", 8'h17, v)
    i_cpu.rd(8'h9D, v);
    `CHK("mult", 8'h5A, v)
    @(posedge clk_sys);
    deep_wake <= 1'b1;
    @(posedge clk_sys);
    deep_wake <= 1'b0;
    zeros();
    $display("done regs");
  endtask : t_regs

  // Expiry, hold at zero, interrupt gating and flag clearing.
  task automatic t_expire();
    i_cpu.wr(8'h9D, 8'h01);
    i_cpu.wr(8'h9E, 8'h10);
    i_cpu.wr(8'h9C, 8'h02);
    wait_dma(300);
    `CHK("period 2", 1'b1, n >= 126 && n <= 131)
    `CHK("cpu flag", 1'b1, cpu_slot_irq_flag)
    `CHK("irq off", 1'b0, irq_req)
    @(posedge clk_sys);
    cpu_slot_irq_enable <= 1'b1;
    repeat (140) @(posedge clk_sys);
    #1;
    `CHK("irq on", 1'b1, irq_req)
    i_cpu.rd(8'h9C, v);
    `CHK("hold zero", 8'h00, v)
    i_cpu.wr(8'h9E, 8'h50);
    i_cpu.rd(8'h9E, v);
    `CHK("flag kept", 8'h50, v)
    i_cpu.wr(8'h9E, 8'h10);
    i_cpu.rd(8'h9E, v);
    `CHK("flag clear", 8'h10, v)
    @(posedge clk_sys);
    cpu_slot_irq_clear <= 1'b1;
    @(posedge clk_sys);
    cpu_slot_irq_clear <= 1'b0;
    cpu_slot_irq_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("cpu clear", 1'b0, cpu_slot_irq_flag)
    $display("done expire");
  endtask : t_expire

  // A count write on the edge of a timer tick stores one less.
  task automatic t_coincide();
    i_cpu.wr(8'h9D, 8'h01);
    i_cpu.wr(8'h9E, 8'h00);
    i_cpu.wr(8'h9C, 8'h05);
    repeat (63) @(posedge clk_sys);
    i_cpu.wr(8'h9C, 8'h10);
    i_cpu.rd(8'h9C, v);
    `CHK("coincide", 8'h0F, v)
    // Writing zero stops the generator for the scenarios that follow.
    i_cpu.wr(8'h9C, 8'h00);
    $display("done coincide");
  endtask : t_coincide

  // Period for every rate code, a larger multiplier, zero as 256 and a
  // system tick on every other cycle only.
  task automatic t_rates();
    int f[7] = '{64, 128, 256, 1024, 128, 16384, 128};
    for (int r = 0; r < 7; r++)
    begin
      i_cpu.wr(8'h9D, r == 4 ? 8'h02 : (r == 5 ? 8'h00 : 8'h01));
      i_cpu.wr(8'h9E, r < 4 ? 8'(r) : 8'h00);
      tick_half <= (r == 6);
      i_cpu.wr(8'h9C, 8'h01);
      wait_dma(20000);
      `CHK("period", 1'b1, n >= f[r]-2 && n <= f[r]+3)
    end
    @(posedge clk_sys);
    tick_half <= 1'b0;
    $display("done rates");
  endtask : t_rates

  // Free run wraps from zero to all ones.
  task automatic t_free();
    i_cpu.wr(8'h9D, 8'h01);
    i_cpu.wr(8'h9E, 8'h04);
    i_cpu.wr(8'h9C, 8'h01);
    wait_dma(300);
    repeat (30) @(posedge clk_sys);
    i_cpu.rd(8'h9C, v);
    `CHK("at zero", 8'h00, v)
    repeat (62) @(posedge clk_sys);
    i_cpu.rd(8'h9C, v);
    `CHK("wrapped", 8'hFF, v)
    $display("done free");
  endtask : t_free

  // Main sequence: reset for 20 cycles, then every scenario.
  initial
  begin
    rst_n = 1'b0;
    deep_wake = 1'b0;
    cpu_slot_irq_enable = 1'b0;
    cpu_slot_irq_clear = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_expire();
    t_coincide();
    t_rates();
    t_free();
    conclude();
  end
endmodule : tb
